// ==== pkg/mpr_pkg.sv ====
// Shared constants and types for the multipurpose register access block.
`default_nettype none
package store_pkg;

	// ---------------------------------------------------------------
	// Store geometry
	// ---------------------------------------------------------------
	localparam int DQ_WIDTH = 8;
	localparam int LOC_WIDTH = 8;
	localparam int BURST_UIS = 8;
	localparam int MR_COUNT = 7;
	localparam int SYNC_WIDTH = 28;

	// Page 0 training patterns loaded at reset and re-initialisation.
	localparam logic [7:0] PATTERN_LOC0 = 8'h55;
	localparam logic [7:0] PATTERN_LOC1 = 8'h33;
	localparam logic [7:0] PATTERN_LOC2 = 8'h0f;
	localparam logic [7:0] PATTERN_LOC3 = 8'h00;

	// ---------------------------------------------------------------
	// Mode register fields
	// ---------------------------------------------------------------
	localparam logic [2:0] MR_SEL_CONFIG_THREE = 3'h3;
	localparam logic [2:0] MR_SEL_FIVE = 3'h5;
	localparam int CFG3_ENABLE_BIT = 2;
	localparam int CFG3_GEARDOWN_BIT = 3;
	localparam int CFG3_PAGE_LSB = 0;
	localparam int CFG3_FORMAT_LSB = 11;
	localparam int MR5_CRC_CLEAR_BIT = 3;
	localparam int MR5_PARITY_CLEAR_BIT = 4;

	// Command codes on {ras_n, cas_n, we_n} with act_n high.
	localparam logic [2:0] CMD_MRS = 3'h0;
	localparam logic [2:0] CMD_REF = 3'h1;
	localparam logic [2:0] CMD_PRE = 3'h2;
	localparam logic [2:0] CMD_WR = 3'h4;
	localparam logic [2:0] CMD_RD = 3'h5;
	localparam logic [2:0] CMD_ZQ = 3'h6;

	// ---------------------------------------------------------------
	// Register bus map and reset values
	// ---------------------------------------------------------------
	localparam logic [11:0] OFS_DEVICE_CONFIG = 12'h000;
	localparam logic [11:0] OFS_VENDOR_PAGE = 12'h004;
	localparam logic [11:0] OFS_MODE_STATUS = 12'h008;
	localparam logic [11:0] OFS_PATTERN_READBACK = 12'h00c;
	localparam logic [7:0] DEVICE_CONFIG_RESET = 8'h48;
	localparam logic [31:0] VENDOR_PAGE_RESET = 32'h00000000;
	localparam logic [3:0] READ_LATENCY_RESET = 4'h4;

	typedef enum logic [1:0] {
		FMT_SERIAL = 2'b00,
		FMT_PARALLEL = 2'b01,
		FMT_STAGGERED = 2'b10,
		FMT_RESERVED = 2'b11
	} readout_format_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_WAIT = 2'b01,
		ST_BURST = 2'b10
	} burst_state_t;

endpackage
`default_nettype wire

// ==== logic/pin_synchronizer.sv ====
// Two-flop synchroniser for a group of pin inputs.
`timescale 1ns/1ps
`default_nettype none
module pin_synchronizer
	import store_pkg::*;
#(
	parameter int WIDTH = SYNC_WIDTH
)
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Pins and their synchronised copies
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] stage_one;

	// The first stage may go metastable, so only the second stage reads it.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			stage_one <= '0;
			sync_out <= '0;
		end
		else
		begin
			stage_one <= async_in;
			sync_out <= stage_one;
		end
	end

endmodule
`default_nettype wire

// ==== logic/pattern_store.sv ====
// Writable training pattern locations of page 0.
`timescale 1ns/1ps
`default_nettype none
module pattern_store
	import store_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	input wire logic reinit,
	// Write port
	input wire logic write_en,
	input wire logic [1:0] write_loc,
	input wire logic [LOC_WIDTH-1:0] write_data,
	// All four locations, location 0 in the low byte
	output logic [4*LOC_WIDTH-1:0] words
);

	localparam logic [4*LOC_WIDTH-1:0] DEFAULTS =
		{PATTERN_LOC3, PATTERN_LOC2, PATTERN_LOC1, PATTERN_LOC0};

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			words <= DEFAULTS; // R17
		else if (reinit)
			words <= DEFAULTS; // R17
		else if (write_en)
			words[write_loc*LOC_WIDTH +: LOC_WIDTH] <= write_data;
	end

endmodule
`default_nettype wire

// ==== logic/dram_multipurpose_register_access.sv ====
// Multipurpose register pages of the DRAM, command decode, burst readout and APB view.
//
// Summary of operation
// R1: Four pages, each with four 8-bit locations.
// R2: Page 0 reads serial, parallel or staggered; other pages only serial.
// R3: Page 3 is vendor data except location 3 low nibble: max activate count.
// R4: Controller enables mode and selects page only through MRS to register three.
// R5: No read data bus inversion during multipurpose reads.
// R6: Register three bit 2 routes reads and writes to the multipurpose store.
// R7: Only MRS, RD, RDA, WR, WRA, DES, REF, RESET allowed in the mode.
// R8: RDA and WRA act as RD and WR; auto-precharge is ignored.
// R9: No power-down or self refresh while the mode is on.
// R10: Only 1x refresh; nothing else within the refresh cycle time after REF.
// R11: Reads and writes finish before a refresh command.
// R12: Register three bits 12:11 pick the format; code 11 reserved.
// R13: Register three bits 1:0 pick the active page.
// R14: Location bit 7 is A7 and first unit interval, bit 0 is A0 and last.
// R15: Page 2 location 0 bits 4:3 report the refresh rate need.
// R16: Bank address bits select the location within the page.
// R17: Page 0 holds default patterns and keeps writes until re-initialisation.
// R18: Page 1 is read-only and latches the failing command on a parity error.
// R19: Page 2 is read-only and reflects mode register settings.
// R20: Writes to pages 1 to 3 change nothing; only page 0 is writable.
//
// Design decisions made here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module dram_multipurpose_register_access
	import store_pkg::*;
#(
	parameter logic [3:0] READ_LATENCY = READ_LATENCY_RESET
)
(
	// APB slave
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// DRAM command pins
	input wire logic ck,
	input wire logic dram_reset_n,
	input wire logic cs_n,
	input wire logic act_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic [1:0] bg,
	input wire logic [1:0] ba,
	input wire logic [13:0] addr,
	input wire logic a17,
	input wire logic par,
	input wire logic crc_error,
	// DRAM data pins
	output logic [DQ_WIDTH-1:0] dq_out,
	output logic dq_oe,
	output logic dqs_out,
	output logic dbi_n_out
);

	// ---------------------------------------------------------------
	// Pin synchronisation and link clock edges
	// ---------------------------------------------------------------
	logic [SYNC_WIDTH-1:0] sync_bus;
	logic s_ck, s_reset_n, s_cs_n, s_act_n, s_ras_n, s_cas_n, s_we_n;
	logic [1:0] s_bg, s_ba;
	logic [13:0] s_addr;
	logic s_a17, s_par, s_crc_error;
	logic ck_prev;

	pin_synchronizer #(.WIDTH(SYNC_WIDTH)) pins_sync (
		.pclk(pclk),
		.presetn(presetn),
		.async_in({crc_error, par, a17, addr, ba, bg, we_n, cas_n, ras_n, act_n, cs_n,
			dram_reset_n, ck}),
		.sync_out(sync_bus)
	);

	assign {s_crc_error, s_par, s_a17, s_addr, s_ba, s_bg, s_we_n, s_cas_n, s_ras_n,
		s_act_n, s_cs_n, s_reset_n, s_ck} = sync_bus;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ck_prev <= 1'b0;
		else
			ck_prev <= s_ck;
	end

	wire logic ck_rise = s_ck & ~ck_prev;
	wire logic ck_edge = s_ck ^ ck_prev;
	wire logic reinit = ~s_reset_n;
	wire logic cmd_valid = ck_rise & ~s_cs_n & s_reset_n;
	wire logic [2:0] cmd_code = {s_ras_n, s_cas_n, s_we_n};
	wire logic cmd_plain = cmd_valid & s_act_n;
	wire logic [2:0] mr_sel = {s_bg[0], s_ba};

	// ---------------------------------------------------------------
	// Mode registers
	// ---------------------------------------------------------------
	logic [13:0] mode_reg [MR_COUNT];
	logic mrs_hit;
	logic store_enable;
	logic [1:0] active_page;
	logic [1:0] active_format;

	assign mrs_hit = cmd_plain && cmd_code == CMD_MRS && mr_sel < 3'(MR_COUNT);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (int i = 0; i < MR_COUNT; i++)
				mode_reg[i] <= '0;
		end
		else if (reinit)
		begin
			for (int i = 0; i < MR_COUNT; i++)
				mode_reg[i] <= '0;
		end
		else if (mrs_hit)
			mode_reg[mr_sel] <= s_addr;
	end

	assign store_enable = mode_reg[MR_SEL_CONFIG_THREE][CFG3_ENABLE_BIT]; // R6
	assign active_page = mode_reg[MR_SEL_CONFIG_THREE][CFG3_PAGE_LSB +: 2]; // R13
	assign active_format = mode_reg[MR_SEL_CONFIG_THREE][CFG3_FORMAT_LSB +: 2]; // R12

	// ---------------------------------------------------------------
	// Command/address parity and error log
	// ---------------------------------------------------------------
	logic [4*LOC_WIDTH-1:0] error_log;
	logic parity_status;
	logic crc_status;
	wire logic parity_enabled = mode_reg[MR_SEL_FIVE][2:0] != 3'h0;
	wire logic parity_bad = ^{s_act_n, s_ras_n, s_cas_n, s_we_n, s_bg, s_ba, s_a17, s_addr,
		s_par};
	wire logic parity_event = cmd_valid & parity_enabled & parity_bad;
	wire logic mr5_write = mrs_hit && mr_sel == MR_SEL_FIVE;

	// Only the first failing command is kept until the status is cleared.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			error_log <= '0;
		else if (reinit)
			error_log <= '0;
		else if (parity_event && !parity_status)
			error_log[3*LOC_WIDTH-1:0] <= {s_par, s_act_n, s_bg, s_ba, s_a17, s_ras_n,
				s_cas_n, s_we_n, s_addr}; // R18
	end

	// A new error in the same cycle as the clearing MRS keeps the flag set.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			parity_status <= 1'b0;
			crc_status <= 1'b0;
		end
		else if (reinit)
		begin
			parity_status <= 1'b0;
			crc_status <= 1'b0;
		end
		else
		begin
			if (parity_event)
				parity_status <= 1'b1; // R18
			else if (mr5_write && !s_addr[MR5_PARITY_CLEAR_BIT])
				parity_status <= 1'b0;
			if (s_crc_error)
				crc_status <= 1'b1; // R18
			else if (mr5_write && !s_addr[MR5_CRC_CLEAR_BIT])
				crc_status <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// Page contents
	// ---------------------------------------------------------------
	logic [7:0] device_config;
	logic [31:0] vendor_page;
	logic [4*LOC_WIDTH-1:0] pattern_words;
	logic [4*LOC_WIDTH-1:0] page_one, page_two, page_three;
	wire logic page_write = cmd_plain && cmd_code == CMD_WR && store_enable && active_page == 2'h0;

	pattern_store page_zero_store (
		.pclk(pclk),
		.presetn(presetn),
		.reinit(reinit),
		.write_en(page_write), // R20
		.write_loc(s_ba), // R16
		.write_data(s_addr[7:0]), // R14
		.words(pattern_words)
	);

	assign page_one = {crc_status, parity_status, mode_reg[MR_SEL_FIVE][2:0], 3'h0,
		error_log[3*LOC_WIDTH-1:0]}; // R18
	assign page_two = {
		mode_reg[1][10:8], mode_reg[5][8:6], mode_reg[2][2:1],
		mode_reg[0][6:4], mode_reg[0][2], mode_reg[0][12], mode_reg[2][5:3],
		mode_reg[6][6], mode_reg[6][5:0], mode_reg[MR_SEL_CONFIG_THREE][CFG3_GEARDOWN_BIT],
		device_config[4], device_config[5], mode_reg[2][11], device_config[7:6], // R15
		mode_reg[2][12], mode_reg[2][10:9]}; // R19
	assign page_three = {vendor_page[31:28], device_config[3:0], vendor_page[23:0]}; // R3

	function automatic logic [4*LOC_WIDTH-1:0] page_words(input logic [1:0] page,
		input logic [4*LOC_WIDTH-1:0] p0, input logic [4*LOC_WIDTH-1:0] p1,
		input logic [4*LOC_WIDTH-1:0] p2, input logic [4*LOC_WIDTH-1:0] p3);
		case (page) // R1
			2'h0: page_words = p0;
			2'h1: page_words = p1;
			2'h2: page_words = p2;
			default: page_words = p3;
		endcase
	endfunction

	// Lane values of one unit interval; bit 7 of a location leaves first.
	function automatic logic [DQ_WIDTH-1:0] lane_bits(input logic [1:0] fmt,
		input logic [1:0] loc, input logic [2:0] beat, input logic [4*LOC_WIDTH-1:0] w);
		logic [1:0] stagger_loc;
		lane_bits = '0;
		for (int k = 0; k < DQ_WIDTH; k++)
		begin
			stagger_loc = loc + 2'(k);
			case (fmt)
				FMT_PARALLEL: lane_bits[k] = w[LOC_WIDTH-1-k]; // R2
				FMT_STAGGERED: lane_bits[k] = w[stagger_loc*LOC_WIDTH + 7 - beat]; // R2
				default: lane_bits[k] = w[loc*LOC_WIDTH + 7 - beat]; // R14
			endcase
		end
	endfunction

	// ---------------------------------------------------------------
	// Read burst
	// ---------------------------------------------------------------
	burst_state_t state;
	logic [3:0] lat_count;
	logic [3:0] beat_count;
	logic [1:0] rd_page;
	logic [1:0] rd_loc;
	logic [1:0] rd_format;
	logic [4*LOC_WIDTH-1:0] rd_words;
	logic [7:0] forbidden_count;
	// Auto-precharge on A10 is not looked at, so RDA behaves as RD.
	wire logic read_start = cmd_plain && cmd_code == CMD_RD && store_enable && state == ST_IDLE; // R8

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state <= ST_IDLE;
			lat_count <= 4'h0;
			beat_count <= 4'h0;
			rd_page <= 2'h0;
			rd_loc <= 2'h0;
			rd_format <= FMT_SERIAL;
			rd_words <= '0;
			dq_out <= '0;
			dq_oe <= 1'b0;
			dqs_out <= 1'b0;
		end
		else if (reinit)
		begin
			state <= ST_IDLE;
			dq_oe <= 1'b0;
			dq_out <= '0;
			dqs_out <= 1'b0;
		end
		else
		begin
			case (state)
				ST_IDLE:
				begin
					if (read_start)
					begin
						state <= ST_WAIT;
						lat_count <= READ_LATENCY - 4'h1;
						rd_page <= active_page;
						rd_loc <= s_ba; // R16
						// Reserved format and pages 1 to 3 fall back to serial.
						rd_format <= (active_page == 2'h0 && active_format != FMT_RESERVED) ?
							active_format : FMT_SERIAL; // R2
						rd_words <= page_words(active_page, pattern_words, page_one,
							page_two, page_three);
					end
				end
				ST_WAIT:
				begin
					if (ck_rise)
					begin
						if (lat_count == 4'h0)
						begin
							state <= ST_BURST;
							dq_out <= lane_bits(rd_format, rd_loc, 3'h0, rd_words);
							dq_oe <= 1'b1;
							dqs_out <= 1'b1;
							beat_count <= 4'h1;
						end
						else
							lat_count <= lat_count - 4'h1;
					end
				end
				ST_BURST:
				begin
					if (ck_edge)
					begin
						if (beat_count == 4'(BURST_UIS))
						begin
							state <= ST_IDLE;
							dq_oe <= 1'b0;
							dqs_out <= 1'b0;
						end
						else
						begin
							dq_out <= lane_bits(rd_format, rd_loc, beat_count[2:0], rd_words);
							dqs_out <= ~beat_count[0];
							beat_count <= beat_count + 4'h1;
						end
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	// Data never go out inverted, whatever the inversion setting says.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			dbi_n_out <= 1'b1;
		else
			dbi_n_out <= 1'b1; // R5
	end

	// Illegal ACT, PRE and ZQ commands in the mode, and refresh during a read's latency wait or burst, are counted.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			forbidden_count <= 8'h00;
		else if (reinit)
			forbidden_count <= 8'h00;
		else if (cmd_valid && store_enable && forbidden_count != 8'hff &&
			(!s_act_n || cmd_code == CMD_PRE || cmd_code == CMD_ZQ || // R7
			(cmd_code == CMD_REF && state != ST_IDLE))) // R11
			forbidden_count <= forbidden_count + 8'h01;
	end

	// ---------------------------------------------------------------
	// APB register file
	// ---------------------------------------------------------------
	wire logic apb_setup_done = psel & penable & ~pready;
	wire logic apb_done = psel & penable & pready;
	wire logic addr_hit = paddr == OFS_DEVICE_CONFIG || paddr == OFS_VENDOR_PAGE ||
		paddr == OFS_MODE_STATUS || paddr == OFS_PATTERN_READBACK;
	logic [31:0] read_mux;

	always_comb
	begin
		case (paddr)
			OFS_DEVICE_CONFIG: read_mux = {24'h000000, device_config};
			OFS_VENDOR_PAGE: read_mux = vendor_page;
			OFS_MODE_STATUS: read_mux = {16'h0000, forbidden_count, state != ST_IDLE,
				crc_status, parity_status, active_format, active_page, store_enable};
			OFS_PATTERN_READBACK: read_mux = pattern_words;
			default: read_mux = 32'h00000000;
		endcase
	end

	// One wait state: pready rises in the second access cycle.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			prdata <= 32'h00000000;
			pslverr <= 1'b0;
		end
		else if (apb_setup_done)
		begin
			pready <= 1'b1;
			prdata <= pwrite ? 32'h00000000 : read_mux;
			pslverr <= ~addr_hit;
		end
		else
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			device_config <= DEVICE_CONFIG_RESET;
			vendor_page <= VENDOR_PAGE_RESET;
		end
		else if (apb_done && pwrite)
		begin
			if (paddr == OFS_DEVICE_CONFIG && pstrb[0])
				device_config <= pwdata[7:0];
			if (paddr == OFS_VENDOR_PAGE)
			begin
				for (int b = 0; b < 4; b++)
					if (pstrb[b])
						vendor_page[b*8 +: 8] <= pwdata[b*8 +: 8];
			end
		end
	end

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	apb_wait_state_a: assert property (@(posedge pclk) disable iff (!presetn) // APB design decision
		apb_setup_done |=> pready ##1 !pready)
		else $error("APB answer not one wait state");
	no_inversion_a: assert property (@(posedge pclk) disable iff (!presetn) // R5
		dq_oe |-> dbi_n_out)
		else $error("inversion flag active during burst");
	mode_bit_follows_a: assert property (@(posedge pclk) disable iff (!presetn) // R6
		mrs_hit && mr_sel == MR_SEL_CONFIG_THREE |=> store_enable == $past(s_addr[2]))
		else $error("mode enable does not follow register three");
	array_read_ignored_a: assert property (@(posedge pclk) disable iff (!presetn) // R6
		cmd_plain && cmd_code == CMD_RD && !store_enable && state == ST_IDLE |=>
		state == ST_IDLE)
		else $error("read started outside access mode");
	page_write_stores_a: assert property (@(posedge pclk) disable iff (!presetn) // R17
		page_write && !reinit |=> pattern_words[$past(s_ba)*8 +: 8] == $past(s_addr[7:0]))
		else $error("page 0 write not stored");
	other_pages_locked_a: assert property (@(posedge pclk) disable iff (!presetn) // R20
		cmd_plain && cmd_code == CMD_WR && active_page != 2'h0 && !reinit |=>
		$stable(pattern_words))
		else $error("write to read-only page changed the store");
	reinit_defaults_a: assert property (@(posedge pclk) disable iff (!presetn) // R17
		reinit |=> pattern_words == {PATTERN_LOC3, PATTERN_LOC2, PATTERN_LOC1, PATTERN_LOC0})
		else $error("patterns not restored on re-initialisation");
	parity_logged_a: assert property (@(posedge pclk) disable iff (!presetn) // R18
		parity_event && !parity_status && !reinit |=> parity_status &&
		error_log[7:0] == $past(s_addr[7:0]))
		else $error("parity error not logged");
	serial_lanes_equal_a: assert property (@(posedge pclk) disable iff (!presetn) // R2
		dq_oe && rd_page != 2'h0 |-> dq_out == '0 || dq_out == '1)
		else $error("non-serial readout from page 1 to 3");
	burst_length_a: assert property (@(posedge pclk) disable iff (!presetn) // R14
		$fell(dq_oe) && !reinit |-> $past(beat_count) == 4'(BURST_UIS))
		else $error("burst did not last eight unit intervals");

endmodule
`default_nettype wire

// ==== verif/dram_ctl_model.sv ====
// Memory controller model that drives the command pins and the command clock.
`timescale 1ns/1ps
`default_nettype none
module dram_ctl_model
(
	// Clock
	input wire logic pclk,
	// Command pins
	output logic ck,
	output logic dram_reset_n,
	output logic cs_n,
	output logic act_n,
	output logic ras_n,
	output logic cas_n,
	output logic we_n,
	output logic [1:0] bg,
	output logic [1:0] ba,
	output logic [13:0] addr,
	output logic a17,
	output logic par
);
	initial
	begin
		ck = 1'b0;
		dram_reset_n = 1'b1;
		cs_n = 1'b1;
		{act_n, ras_n, cas_n, we_n, a17} = 5'h1f;
		{bg, ba, addr} = 18'h0;
	end

	// Even parity keeps the check quiet; the flip makes one bad command on purpose.
	logic par_flip = 1'b0;
	assign par = ^{act_n, ras_n, cas_n, we_n, bg, ba, a17, addr} ^ par_flip;

	// The clock runs only inside a frame, eight pclk a half period.
	task automatic run_ck(input int n);
		repeat (2 * n)
		begin
			repeat (8) @(posedge pclk);
			ck <= ~ck;
		end
	endtask

	// Mode and page change only by MRS; no REF, power-down or self refresh is sent.
	// Location rides on the bank inputs, write data on A7..A0, bit 7 on A7.
	task automatic cmd(input logic a, input logic [2:0] c, input logic [1:0] g,
		input logic [1:0] b, input logic [13:0] ad, input int tail);
		@(posedge pclk);
		cs_n <= 1'b0;
		act_n <= a;
		{ras_n, cas_n, we_n} <= c;
		bg <= g;
		ba <= b;
		addr <= ad;
		run_ck(1);
		// Released lines show the inverse so a stale value is never mistaken for a hold.
		cs_n <= 1'b1;
		{act_n, ras_n, cas_n, we_n} <= ~{a, c};
		{bg, ba, addr} <= ~{g, b, ad};
		run_ck(tail);
	endtask

	task automatic reinit();
		@(posedge pclk);
		dram_reset_n <= 1'b0;
		repeat (8) @(posedge pclk);
		dram_reset_n <= 1'b1;
		repeat (8) @(posedge pclk);
	endtask
endmodule
`default_nettype wire

// ==== verif/tb_top.sv ====
// Self-checking bench for the multipurpose register block.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import store_pkg::*;
	localparam logic [3:0] LAT = 4'h3;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, r;
	logic pready, pslverr, e, ck, dram_reset_n, cs_n, act_n, ras_n, cas_n, we_n, a17, par;
	logic [1:0] bg, ba;
	logic [13:0] addr;
	logic [7:0] dq_out, cfg, d;
	logic dq_oe, dqs_out, dbi_n_out, oe_q, dqs_q;
	logic [7:0] beat_q [$];
	logic crc_error = 1'b0;
	logic [7:0] mem [4][4];
	int err_total = 0;
	int compares = 0;
	int seed = 83555;

	always #5 pclk = ~pclk;

	dram_multipurpose_register_access #(.READ_LATENCY(LAT)) i_dut (
		.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .ck(ck), .dram_reset_n(dram_reset_n), .cs_n(cs_n), .act_n(act_n),
		.ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .bg(bg), .ba(ba), .addr(addr), .a17(a17),
		.par(par), .crc_error(crc_error), .dq_out(dq_out), .dq_oe(dq_oe), .dqs_out(dqs_out),
		.dbi_n_out(dbi_n_out));

	dram_ctl_model i_ctl (.pclk(pclk), .ck(ck), .dram_reset_n(dram_reset_n), .cs_n(cs_n),
		.act_n(act_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .bg(bg), .ba(ba),
		.addr(addr), .a17(a17), .par(par));

	task automatic stop_test();
		$display("compares=%0d err_total=%0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			err_total++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// A new unit interval starts where the strobe toggles or the burst begins.
	always @(posedge pclk)
	begin
		if (dq_oe === 1'b1 && (oe_q !== 1'b1 || dqs_out !== dqs_q))
		begin
			beat_q.push_back(dq_out);
			check(32'(dbi_n_out), 32'h1);
		end
		oe_q <= dq_oe;
		dqs_q <= dqs_out;
	end

	function automatic logic [7:0] exp_beat(input logic [1:0] f, input logic [1:0] p,
		input logic [1:0] b, input int u);
		logic [7:0] v;
		for (int k = 0; k < 8; k++)
			if (p == 2'h0 && f == 2'h1)
				v[k] = mem[0][0][7-k];
			else if (p == 2'h0 && f == 2'h2)
				v[k] = mem[0][2'(b + 2'(k))][7-u];
			else
				v[k] = mem[p][b][7-u];
		return v;
	endfunction

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] dat,
		output logic [31:0] rd, output logic er);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= w;
		pwdata <= dat;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do @(posedge pclk); while (pready !== 1'b1 && ++n < 50);
		rd = prdata;
		er = pslverr;
		if (n >= 50)
		begin
			err_total++;
			stop_test();
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd_reg(input logic [11:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0, r, e);
		check(r, x);
	endtask

	task automatic mode(input logic [1:0] f, input logic [1:0] p);
		i_ctl.cmd(1'b1, CMD_MRS, 2'h0, 2'h3, {1'b0, f, 8'h00, 1'b1, p}, 2);
	endtask

	// A10 set makes every read an RDA, whose precharge part must be ignored.
	task automatic rd_check(input logic [1:0] f, input logic [1:0] p, input logic [1:0] b,
		input logic on);
		beat_q.delete();
		i_ctl.cmd(1'b1, CMD_RD, 2'h0, b, 14'h0400, int'(LAT) + 5);
		check(32'(beat_q.size()), on ? 32'd8 : 32'd0);
		for (int u = 0; u < 8 && on; u++)
			if (p != 2'h3 || (b == 2'h3 && u > 3))
				check(32'(beat_q[u]), 32'(exp_beat(f, p, b, u)));
		check(32'(dq_oe), 32'h0);
	endtask

	initial
	begin
		foreach (mem[p, l]) mem[p][l] = 8'h00;
		mem[0] = '{PATTERN_LOC0, PATTERN_LOC1, PATTERN_LOC2, PATTERN_LOC3};
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		rd_reg(OFS_DEVICE_CONFIG, 32'h48);
		rd_reg(OFS_VENDOR_PAGE, 32'h0);
		rd_reg(OFS_PATTERN_READBACK, 32'h000f3355);
		apb(1'b1, OFS_MODE_STATUS, 32'hff, r, e);
		rd_reg(OFS_MODE_STATUS, 32'h0);
		apb(1'b0, 12'h010, 32'h0, r, e);
		check({r[30:0], e}, 32'h1);
		cfg = 8'($random(seed));
		apb(1'b1, OFS_DEVICE_CONFIG, {24'h0, cfg}, r, e);
		rd_reg(OFS_DEVICE_CONFIG, {24'h0, cfg});
		mem[3][3] = {4'h0, cfg[3:0]};
		mem[2][0] = {cfg[4], cfg[5], 1'b0, cfg[7:6], 3'h0};
		rd_check(2'h0, 2'h0, 2'h1, 1'b0);
		mode(2'h0, 2'h0);
		rd_reg(OFS_MODE_STATUS, 32'h1);
		for (int b = 0; b < 4; b++)
		begin
			d = 8'($random(seed));
			i_ctl.cmd(1'b1, CMD_WR, 2'h0, 2'(b), {3'h0, b[0], 2'h0, d}, 2);
			mem[0][b] = d;
		end
		rd_reg(OFS_PATTERN_READBACK, {mem[0][3], mem[0][2], mem[0][1], mem[0][0]});
		for (int f = 0; f < 4; f++)
		begin
			mode(2'(f), 2'h0);
			for (int b = 0; b < 4; b++) rd_check(2'(f), 2'h0, 2'(b), 1'b1);
		end
		for (int p = 1; p < 4; p++)
		begin
			mode(2'h1, 2'(p));
			i_ctl.cmd(1'b1, CMD_WR, 2'h0, 2'h3, 14'h00a5, 2);
			for (int b = 0; b < 4; b++) rd_check(2'h0, 2'(p), 2'(b), 1'b1);
		end
		// Bad parity on the page-select command is logged with both sticky flags.
		i_ctl.cmd(1'b1, CMD_MRS, 2'h1, 2'h1, 14'h0019, 2);
		crc_error <= 1'b1;
		i_ctl.par_flip <= 1'b1;
		mode(2'h0, 2'h1);
		crc_error <= 1'b0;
		i_ctl.par_flip <= 1'b0;
		mem[1] = '{8'h05, 8'h00, 8'hce, 8'hc8};
		for (int b = 0; b < 4; b++) rd_check(2'h0, 2'h1, 2'(b), 1'b1);
		i_ctl.cmd(1'b1, CMD_MRS, 2'h1, 2'h1, 14'h0001, 2);
		mode(2'h0, 2'h0);
		i_ctl.cmd(1'b0, 3'h7, 2'h0, 2'h0, 14'h0000, 2);
		i_ctl.cmd(1'b1, CMD_PRE, 2'h0, 2'h0, 14'h0000, 2);
		i_ctl.cmd(1'b1, CMD_ZQ, 2'h0, 2'h0, 14'h0000, 2);
		rd_reg(OFS_MODE_STATUS, 32'h301);
		i_ctl.reinit();
		rd_reg(OFS_MODE_STATUS, 32'h0);
		rd_reg(OFS_PATTERN_READBACK, 32'h000f3355);
		stop_test();
	end
endmodule
`default_nettype wire
